// ==== common/qbc_pkg.sv ====
package qbc_pkg;

  // Register offsets on the serial port's register index.
  localparam logic [7:0] OFS_REVISION      = 8'h01;
  localparam logic [7:0] OFS_CONV0_CTRL_A  = 8'h02;
  localparam logic [7:0] OFS_CONV0_CTRL_B  = 8'h03;
  localparam logic [7:0] OFS_INT_TOP       = 8'h18;
  localparam logic [7:0] OFS_INT_CONV01    = 8'h19;
  localparam logic [7:0] OFS_INT_CONV23    = 8'h1a;
  localparam logic [7:0] OFS_STAT_TOP      = 8'h1b;
  localparam logic [7:0] OFS_STAT_CONV01   = 8'h1c;
  localparam logic [7:0] OFS_STAT_CONV23   = 8'h1d;
  localparam logic [7:0] OFS_MASK_TOP      = 8'h1e;
  localparam logic [7:0] OFS_MASK_CONV01   = 8'h1f;
  localparam logic [7:0] OFS_MASK_CONV23   = 8'h20;
  localparam logic [7:0] OFS_LOAD_SELECT   = 8'h21;
  localparam logic [7:0] OFS_LOAD_HIGH     = 8'h22;
  localparam logic [7:0] OFS_LOAD_LOW      = 8'h23;

  // Field positions in control register A.
  localparam int BIT_ON        = 7;
  localparam int BIT_PIN_GATE  = 6;
  localparam int BIT_PIN_PICK  = 5;
  localparam int BIT_HIGH_LOW  = 4;
  localparam int BIT_DISCHARGE = 3;
  localparam int BIT_FIXED     = 1;

  // Field positions in control register B.
  localparam int ILIM_LSB = 3;
  localparam int RAMP_LSB = 0;

  // Writable bits of the sparse registers.
  localparam logic [7:0] CTRL_A_WMASK   = 8'hfa;
  localparam logic [7:0] CTRL_B_WMASK   = 8'h3f;
  localparam logic [7:0] INT_CONV_WMASK = 8'h77;
  localparam logic [7:0] MASK_TOP_WMASK = 8'h07;
  localparam logic [7:0] MASK_CONV_WMASK = 8'h55;
  localparam logic [7:0] INT_TOP_WMASK  = 8'hff;

  // Values after reset, before the nonvolatile reload.
  localparam logic [7:0] CTRL_A_RESET = 8'hca;
  localparam logic [7:0] CTRL_B_RESET = 8'h32;
  localparam logic [7:0] ZERO_RESET   = 8'h00;

  // Bits of control register A and B taken from nonvolatile memory.
  localparam logic [7:0] CTRL_A_NV_BITS = 8'he2;
  localparam logic [7:0] CTRL_B_NV_BITS = 8'h3f;

  // Lowest valid current-limit code.
  localparam logic [2:0] ILIM_MIN_CODE = 3'h2;

  // Serial port transfer phases.
  typedef enum logic [1:0] {
    QBC_IDLE = 2'b00,
    QBC_INDEX = 2'b01,
    QBC_DATA = 2'b11
  } qbc_phase_e;

endpackage

// ==== rtl/qbc_regs.sv ====
// Overview of operation
// - Bit 7 switches converter 0 on/off.
// - Bit 6 gates converter with selected pin.
// - Bit 5 picks enable pin one or two.
// - Bit 4: pin enables or picks floor voltage.
// - Bit 3 connects discharge resistor while off.
// - Bit 1 forces fixed pulse-width mode.
// - Limit codes 2..7 map 2.5 A..5.0 A.
// - Limit writes apply live, no disable needed.
// - Ramp code sets both ramp directions.
// - Nonvolatile defaults reload during memory read.
// - Writes auto-increment index; reads do not.
module qbc_regs (
  input  wire logic       clk_sys,
  input  wire logic       rst,
  // Byte-level serial port: start, stop, and received byte strobes.
  input  wire logic       bus_start,
  input  wire logic       bus_stop,
  input  wire logic       bus_rnw,
  input  wire logic       bus_byte_valid,
  input  wire logic [7:0] bus_byte,
  // Read request for the byte the host is about to clock out.
  input  wire logic       bus_read_req,
  output logic      [7:0] bus_read_data,
  // Nonvolatile memory reload strobe and its image.
  input  wire logic       nv_load,
  input  wire logic [7:0] nv_revision_code,
  input  wire logic [7:0] nv_ctrl_a,
  input  wire logic [7:0] nv_ctrl_b,
  // External enable pins.
  input  wire logic       enable_pin_one,
  input  wire logic       enable_pin_two,
  // Live conditions from the analog converters.
  input  wire logic [3:0] power_good,
  input  wire logic [3:0] current_limit_hit,
  input  wire logic [3:0] short_circuit,
  input  wire logic [3:0] converter_running,
  input  wire logic       temp_warning,
  input  wire logic       temp_shutdown,
  input  wire logic       reset_event,
  input  wire logic       load_ready,
  input  wire logic [9:0] load_current,
  // Converter 0 control outputs.
  output logic            converter0_run,
  output logic            converter0_floor_sel,
  output logic            converter0_discharge,
  output logic            converter0_fixed_mode,
  output logic      [2:0] converter0_current_limit_code,
  output logic      [2:0] converter0_ramp_rate_code,
  output logic            irq_n
);

  // Stored registers.
  // Reserved and non-writable bits are held at zero by the write masks.
  logic [7:0] revision_code;      // Nonvolatile revision code.
  logic [7:0] ctrl_a;             // Converter 0 control A.
  logic [7:0] ctrl_b;             // Converter 0 control B.
  logic [7:0] int_top;            // Top-level flags.
  logic [7:0] int_c01;            // Converter 0/1 flags.
  logic [7:0] int_c23;            // Converter 2/3 flags.
  logic [7:0] mask_top;           // Top-level masks.
  logic [7:0] mask_c01;           // Converter 0/1 masks.
  logic [7:0] mask_c23;           // Converter 2/3 masks.
  logic [7:0] load_sel;           // Load measurement converter select.
  logic [7:0] load_hi;            // Load current upper bits.
  logic [7:0] load_lo;            // Load current lower bits.

  // Serial port state.
  // A read frame restarts into the index phase but sends no byte, so nothing is written.
  qbc_pkg::qbc_phase_e phase;     // Transfer phase.
  logic [7:0]          index;     // Register index.

  // Write decode.
  logic       wr_strobe;
  logic       idx_strobe;
  logic [7:0] wr_data;
  logic       wr_ctrl_a;
  logic       wr_ctrl_b;
  logic       wr_int_top;
  logic       wr_int_c01;
  logic       wr_int_c23;
  logic       wr_mask_top;
  logic       wr_mask_c01;
  logic       wr_mask_c23;
  logic       wr_load_sel;

  // Event sources for flag registers.
  logic [7:0] ev_top;
  logic [7:0] ev_c01;
  logic [7:0] ev_c23;

  // Live status images.
  logic [7:0] stat_top;
  logic [7:0] stat_c01;
  logic [7:0] stat_c23;

  // Converter 0 control decode.
  logic pin_sel;
  logic pin_on;
  logic pin_floor;
  logic next_run;
  logic next_floor;
  logic next_discharge;
  logic any_irq;
  logic [7:0] next_read;

  // The first byte after the address is the index; later bytes are data.
  assign idx_strobe = bus_byte_valid && !bus_rnw && (phase == qbc_pkg::QBC_INDEX);
  assign wr_strobe  = bus_byte_valid && !bus_rnw && (phase == qbc_pkg::QBC_DATA);
  assign wr_data    = bus_byte;

  // One strobe per register, so a data byte touches only the register at the index.
  assign wr_ctrl_a   = wr_strobe && (index == qbc_pkg::OFS_CONV0_CTRL_A);
  assign wr_ctrl_b   = wr_strobe && (index == qbc_pkg::OFS_CONV0_CTRL_B);
  assign wr_int_top  = wr_strobe && (index == qbc_pkg::OFS_INT_TOP);
  assign wr_int_c01  = wr_strobe && (index == qbc_pkg::OFS_INT_CONV01);
  assign wr_int_c23  = wr_strobe && (index == qbc_pkg::OFS_INT_CONV23);
  assign wr_mask_top = wr_strobe && (index == qbc_pkg::OFS_MASK_TOP);
  assign wr_mask_c01 = wr_strobe && (index == qbc_pkg::OFS_MASK_CONV01);
  assign wr_mask_c23 = wr_strobe && (index == qbc_pkg::OFS_MASK_CONV23);
  assign wr_load_sel = wr_strobe && (index == qbc_pkg::OFS_LOAD_SELECT);

  // Flag events, laid out as the flag registers are.
  // The per-converter summary bits of the top flags are not produced here and stay zero.
  assign ev_top = {4'h0, temp_shutdown, temp_warning, reset_event, load_ready};
  assign ev_c01 = {1'b0, ~power_good[1], short_circuit[1], current_limit_hit[1],
                   1'b0, ~power_good[0], short_circuit[0], current_limit_hit[0]};
  assign ev_c23 = {1'b0, ~power_good[3], short_circuit[3], current_limit_hit[3],
                   1'b0, ~power_good[2], short_circuit[2], current_limit_hit[2]};

  assign stat_top = {4'h0, temp_warning, 3'h0};
  assign stat_c01 = {converter_running[1], power_good[1], 1'b0, current_limit_hit[1],
                     converter_running[0], power_good[0], 1'b0, current_limit_hit[0]};
  assign stat_c23 = {converter_running[3], power_good[3], 1'b0, current_limit_hit[3],
                     converter_running[2], power_good[2], 1'b0, current_limit_hit[2]};

  assign pin_sel   = ctrl_a[qbc_pkg::BIT_PIN_PICK] ? enable_pin_two : enable_pin_one;
  // pin enable versus floor
  // In floor mode the pin no longer switches the converter off; it only picks the voltage.
  assign pin_on    = ctrl_a[qbc_pkg::BIT_HIGH_LOW] ? 1'b1 : pin_sel;
  assign pin_floor = ctrl_a[qbc_pkg::BIT_PIN_GATE] && ctrl_a[qbc_pkg::BIT_HIGH_LOW] && !pin_sel;
  assign next_run   = ctrl_a[qbc_pkg::BIT_ON] && (!ctrl_a[qbc_pkg::BIT_PIN_GATE] || pin_on);
  assign next_floor = pin_floor;
  // Discharge follows the next run value, so it can never overlap a running converter.
  // discharge only while off
  assign next_discharge = !next_run && ctrl_a[qbc_pkg::BIT_DISCHARGE];

  // masked flags do not interrupt
  // Short-circuit and shutdown flags have no mask bit, so they always reach the line.
  // A mask position that was never set reads as zero and leaves its flag unmasked.
  assign any_irq = |(int_top[3:0] & ~mask_top[3:0])
                 | |(int_c01 & ~mask_c01 & qbc_pkg::INT_CONV_WMASK)
                 | |(int_c23 & ~mask_c23 & qbc_pkg::INT_CONV_WMASK)
                 | |int_top[7:4];

  // Read selection; unmapped indices read as zero.
  // The selection feeds a flop, so a late decode never reaches the bus directly.
  always_comb
  begin
    unique case (index)
      qbc_pkg::OFS_REVISION:     next_read = revision_code;
      qbc_pkg::OFS_CONV0_CTRL_A: next_read = ctrl_a;
      qbc_pkg::OFS_CONV0_CTRL_B: next_read = ctrl_b;
      qbc_pkg::OFS_INT_TOP:      next_read = int_top;
      qbc_pkg::OFS_INT_CONV01:   next_read = int_c01;
      qbc_pkg::OFS_INT_CONV23:   next_read = int_c23;
      qbc_pkg::OFS_STAT_TOP:     next_read = stat_top;
      qbc_pkg::OFS_STAT_CONV01:  next_read = stat_c01;
      qbc_pkg::OFS_STAT_CONV23:  next_read = stat_c23;
      qbc_pkg::OFS_MASK_TOP:     next_read = mask_top;
      qbc_pkg::OFS_MASK_CONV01:  next_read = mask_c01;
      qbc_pkg::OFS_MASK_CONV23:  next_read = mask_c23;
      qbc_pkg::OFS_LOAD_SELECT:  next_read = load_sel;
      qbc_pkg::OFS_LOAD_HIGH:    next_read = load_hi;
      qbc_pkg::OFS_LOAD_LOW:     next_read = load_lo;
      default:                   next_read = 8'h00;
    endcase
  end

  // Serial phase and index. A read leaves the index alone.
  // A stop ends the frame from any phase, so a cut frame never leaves a write armed.
  // The index survives the stop, so a read after a restart uses the index just sent.
  always_ff @(posedge clk_sys)
  begin
    if (rst || bus_stop)
    begin
      phase <= qbc_pkg::QBC_IDLE;
    end
    else if (bus_start)
    begin
      phase <= qbc_pkg::QBC_INDEX;
    end
    else if (idx_strobe)
    begin
      phase <= qbc_pkg::QBC_DATA;
    end
    if (rst)
    begin
      index <= 8'h00;
    end
    else if (idx_strobe)
    begin
      index <= bus_byte;
    end
    else if (wr_strobe)
    begin
      index <= index + 8'h01;
    end
  end

  // Converter 0 controls. The nonvolatile reload replaces marked defaults.
  always_ff @(posedge clk_sys)
  begin
    if (rst)
    begin
      ctrl_a        <= qbc_pkg::CTRL_A_RESET;
      ctrl_b        <= qbc_pkg::CTRL_B_RESET;
      revision_code <= qbc_pkg::ZERO_RESET;
    end
    // nonvolatile default reload
    // The reload wins over a write in the same cycle; software should wait for it.
    else if (nv_load)
    begin
      ctrl_a <= (ctrl_a & ~qbc_pkg::CTRL_A_NV_BITS) | (nv_ctrl_a & qbc_pkg::CTRL_A_NV_BITS);
      ctrl_b <= (ctrl_b & ~qbc_pkg::CTRL_B_NV_BITS) | (nv_ctrl_b & qbc_pkg::CTRL_B_NV_BITS);
      revision_code <= nv_revision_code;
    end
    else
    begin
      if (wr_ctrl_a)
      begin
        ctrl_a <= wr_data & qbc_pkg::CTRL_A_WMASK;
      end
      // No disable cycle is needed: the new code reaches the output one edge later.
      // limit applied live
      if (wr_ctrl_b)
      begin
        ctrl_b <= wr_data & qbc_pkg::CTRL_B_WMASK;
      end
    end
  end

  // Flags: write one to clear, but a new event wins over the clear.
  // Events are levels, so a flag keeps setting while its condition lasts; software
  // clears it only after the cause has gone away.
  always_ff @(posedge clk_sys)
  begin
    if (rst)
    begin
      int_top <= qbc_pkg::ZERO_RESET;
      int_c01 <= qbc_pkg::ZERO_RESET;
      int_c23 <= qbc_pkg::ZERO_RESET;
    end
    else
    begin
      int_top <= (int_top & ~(wr_int_top ? wr_data & qbc_pkg::INT_TOP_WMASK : 8'h00)) | ev_top;
      int_c01 <= (int_c01 & ~(wr_int_c01 ? wr_data : 8'h00)) | (ev_c01 & qbc_pkg::INT_CONV_WMASK);
      int_c23 <= (int_c23 & ~(wr_int_c23 ? wr_data : 8'h00)) | (ev_c23 & qbc_pkg::INT_CONV_WMASK);
    end
  end

  // Masks and load measurement. Status registers have no write path.
  // Only bits with a mask position can be set; the others always read as zero.
  always_ff @(posedge clk_sys)
  begin
    if (rst)
    begin
      mask_top <= qbc_pkg::ZERO_RESET;
      mask_c01 <= qbc_pkg::ZERO_RESET;
      mask_c23 <= qbc_pkg::ZERO_RESET;
      load_sel <= qbc_pkg::ZERO_RESET;
      load_hi  <= qbc_pkg::ZERO_RESET;
      load_lo  <= qbc_pkg::ZERO_RESET;
    end
    else
    begin
      if (wr_mask_top)
      begin
        mask_top <= wr_data & qbc_pkg::MASK_TOP_WMASK;
      end
      if (wr_mask_c01)
      begin
        mask_c01 <= wr_data & qbc_pkg::MASK_CONV_WMASK;
      end
      if (wr_mask_c23)
      begin
        mask_c23 <= wr_data & qbc_pkg::MASK_CONV_WMASK;
      end
      if (wr_load_sel)
      begin
        load_sel <= {6'h00, wr_data[1:0]};
      end
      // Measurement results are captured when the converter reports ready.
      // Both halves are taken on one edge, so high and low never come from two samples.
      if (load_ready)
      begin
        load_hi <= {6'h00, load_current[9:8]};
        load_lo <= load_current[7:0];
      end
    end
  end

  // Registered outputs.
  // Every output is flopped so the analog side never sees decode glitches.
  always_ff @(posedge clk_sys)
  begin
    if (rst)
    begin
      converter0_run                <= 1'b0;
      converter0_floor_sel          <= 1'b0;
      converter0_discharge          <= 1'b0;
      converter0_fixed_mode         <= 1'b0;
      converter0_current_limit_code <= qbc_pkg::ILIM_MIN_CODE;
      converter0_ramp_rate_code     <= 3'h0;
      irq_n                         <= 1'b1;
      bus_read_data                 <= 8'h00;
    end
    else
    begin
      converter0_run        <= next_run;
      converter0_floor_sel  <= next_floor;
      converter0_discharge  <= next_discharge;
      converter0_fixed_mode <= ctrl_a[qbc_pkg::BIT_FIXED];
      // codes below two clamp up
      // Codes 0 and 1 have no defined limit; clamping keeps the converter on a valid one.
      converter0_current_limit_code <= (ctrl_b[qbc_pkg::ILIM_LSB +: 3] < qbc_pkg::ILIM_MIN_CODE)
                                     ? qbc_pkg::ILIM_MIN_CODE : ctrl_b[qbc_pkg::ILIM_LSB +: 3];
      converter0_ramp_rate_code <= ctrl_b[qbc_pkg::RAMP_LSB +: 3];
      irq_n <= !any_irq;
      if (bus_read_req)
      begin
        bus_read_data <= next_read;
      end
    end
  end

endmodule

// ==== sim/qbc_regs_asserts.sv ====
module qbc_regs_asserts (
  input wire logic       clk_sys,
  input wire logic       rst,
  input wire logic       bus_byte_valid,
  input wire logic       bus_read_req,
  input wire logic [7:0] bus_read_data,
  input wire logic       nv_load,
  input wire logic       enable_pin_one,
  input wire logic       enable_pin_two,
  input wire logic       converter0_run,
  input wire logic       converter0_discharge,
  input wire logic       converter0_fixed_mode,
  input wire logic [2:0] converter0_current_limit_code,
  input wire logic [2:0] converter0_ramp_rate_code,
  input wire logic       irq_n
);
  timeunit 1ns;
  timeprecision 1ns;
  default clocking @(posedge clk_sys); endclocking
  default disable iff (rst);

  // A cycle with no byte, no reload and steady pins; three in a row cover the output latency.
  sequence quiet_s;
    !bus_byte_valid && !nv_load && $stable(enable_pin_one) && $stable(enable_pin_two);
  endsequence

  a_reset_run_off: assert property ($fell(rst) |-> !converter0_run && !converter0_discharge)
    else $error("converter outputs not cleared by reset");
  a_reset_codes: assert property ($fell(rst) |->
    converter0_current_limit_code == 3'h2 && converter0_ramp_rate_code == 3'h0)
    else $error("limit or ramp code wrong after reset");
  a_reset_idle_bus: assert property ($fell(rst) |-> irq_n && bus_read_data == 8'h00)
    else $error("interrupt or read data active after reset");
  a_discharge_off: assert property (converter0_discharge |-> !converter0_run)
    else $error("discharge connected while converter runs");
  a_limit_floor: assert property (converter0_current_limit_code >= qbc_pkg::ILIM_MIN_CODE)
    else $error("current limit code below lowest valid code");
  a_read_holds: assert property (!bus_read_req |=> $stable(bus_read_data))
    else $error("read data moved without a read request");
  a_quiet_ctrl: assert property (quiet_s [*3] |=> $stable(converter0_fixed_mode) &&
    $stable(converter0_current_limit_code) && $stable(converter0_ramp_rate_code))
    else $error("control field moved without a write");
  a_quiet_run: assert property (quiet_s [*3] |=> $stable(converter0_run))
    else $error("run state moved without a write or pin change");

  c_run_rise: cover property ($rose(converter0_run));
  c_irq_fall: cover property ($fell(irq_n));
  c_read_req: cover property (bus_read_req);
endmodule

bind qbc_regs qbc_regs_asserts qbc_regs_asserts_i (
  .clk_sys, .rst, .bus_byte_valid, .bus_read_req, .bus_read_data, .nv_load,
  .enable_pin_one, .enable_pin_two, .converter0_run, .converter0_discharge,
  .converter0_fixed_mode, .converter0_current_limit_code, .converter0_ramp_rate_code, .irq_n
);

// ==== sim/qbc_host.sv ====
module qbc_host (
  input  wire logic       clk_sys,
  output logic            bus_start,
  output logic            bus_stop,
  output logic            bus_rnw,
  output logic            bus_byte_valid,
  output logic      [7:0] bus_byte,
  output logic            bus_read_req,
  input  wire logic [7:0] bus_read_data
);
  timeunit 1ns;
  timeprecision 1ns;

  // The serial port is idle at time zero.
  initial
  begin
    {bus_start, bus_stop, bus_rnw, bus_byte_valid, bus_read_req} = 5'h00;
    bus_byte = 8'h00;
  end

  // One strobe for one sampling edge, then a gap edge so strobes never merge.
  task automatic tick(ref logic s);
    s = 1'b1;
    @(negedge clk_sys);
    s = 1'b0;
    @(negedge clk_sys);
  endtask

  // A released byte lane shows the inverse, never the stale value.
  task automatic send(input logic [7:0] b);
    bus_byte = b;
    tick(bus_byte_valid);
    bus_byte = ~b;
  endtask

  task automatic wr(input logic [7:0] idx, input int n, input logic [7:0] d0, d1);
    @(negedge clk_sys);
    bus_rnw = 1'b0;
    tick(bus_start);
    send(idx);
    send(d0);
    if (n > 1)
      send(d1);
    tick(bus_stop);
  endtask

  task automatic rd(input logic [7:0] idx, output logic [7:0] d);
    @(negedge clk_sys);
    bus_rnw = 1'b0;
    tick(bus_start);
    send(idx);
    bus_rnw = 1'b1;
    tick(bus_start);
    tick(bus_read_req);
    d = bus_read_data;
    tick(bus_stop);
  endtask
endmodule

// ==== sim/tb_qbc_regs.sv ====
`define CHK(nm, ex, got) \
  begin \
    checks++; \
    if ((got) !== (ex)) \
    begin \
      errors++; \
      $display("mismatch %s expected %h seen %h", nm, ex, got); \
    end \
  end

module tb_qbc_regs;
  timeunit 1ns;
  timeprecision 1ns;
  logic       clk_sys = 1'b0;
  logic       rst = 1'b1;
  logic       bus_start, bus_stop, bus_rnw, bus_byte_valid, bus_read_req;
  logic [7:0] bus_byte, bus_read_data, rd;
  logic [7:0] nv_revision_code = 8'h5a;  // Arbitrary revision image.
  logic [7:0] nv_ctrl_a = 8'h00;
  logic [7:0] nv_ctrl_b = 8'h09;
  logic       nv_load = 1'b0;
  logic       enable_pin_one = 1'b0;
  logic       enable_pin_two = 1'b0;
  logic       temp_warning = 1'b0;
  logic [3:0] power_good = 4'hf;         // All rails good, so no power-good events.
  logic [3:0] current_limit_hit = 4'h0;
  logic [3:0] converter_running = 4'h1;
  logic [3:0] short_circuit = 4'h0;
  logic       load_ready = 1'b0;
  logic [9:0] load_current = 10'h000;
  logic       converter0_run, converter0_floor_sel, converter0_discharge;
  logic       converter0_fixed_mode, irq_n;
  logic [2:0] converter0_current_limit_code, converter0_ramp_rate_code;
  int         errors = 0;
  int         checks = 0;
  // Row: control byte, pin one in bit 5, pin two in bit 4, run, floor, discharge, fixed.
  logic [15:0] rows [11] = '{16'h8008, 16'h0000, 16'h0802, 16'hc000, 16'hc028, 16'he020,
                             16'he018, 16'hd00c, 16'hd028, 16'h8209, 16'hc802};

  // Clock of 100 ns.
  always #50 clk_sys = ~clk_sys;

  qbc_host qbc_host_i (.clk_sys, .bus_start, .bus_stop, .bus_rnw, .bus_byte_valid, .bus_byte,
    .bus_read_req, .bus_read_data);

  qbc_regs qbc_regs_i (.clk_sys, .rst, .bus_start, .bus_stop, .bus_rnw, .bus_byte_valid,
    .bus_byte, .bus_read_req, .bus_read_data, .nv_load, .nv_revision_code, .nv_ctrl_a,
    .nv_ctrl_b, .enable_pin_one, .enable_pin_two, .power_good, .current_limit_hit,
    .short_circuit, .converter_running, .temp_warning, .temp_shutdown(1'b0),
    .reset_event(1'b0), .load_ready, .load_current, .converter0_run,
    .converter0_floor_sel, .converter0_discharge, .converter0_fixed_mode,
    .converter0_current_limit_code, .converter0_ramp_rate_code, .irq_n);

  // Prints the counts and the verdict, then stops.
  task automatic finish_test;
    $display("checks %0d errors %0d", checks, errors);
    if (errors == 0 && checks > 0)
      $display("== PASSED ==");
    else
      $display("== FAILED ==");
    $finish;
  endtask

  // Lets outputs settle a fixed three cycles before the next check.
  task automatic settle;
    repeat (3) @(negedge clk_sys);
  endtask

  // A hung run counts as a mismatch.
  initial
  begin
    repeat (20000) @(posedge clk_sys);
    errors++;
    finish_test();
  end

  initial
  begin
    repeat (4) @(negedge clk_sys);
    rst = 1'b0;
    settle();
    qbc_host_i.rd(qbc_pkg::OFS_CONV0_CTRL_A, rd);
    `CHK("ctrl_a", 8'hca, rd)
    `CHK("ilim_rst", 3'h6, converter0_current_limit_code)
    $display("test reset done");
    foreach (rows[i])
    begin
      {enable_pin_one, enable_pin_two} = rows[i][5:4];
      qbc_host_i.wr(qbc_pkg::OFS_CONV0_CTRL_A, 1, rows[i][15:8], 8'h00);
      settle();
      `CHK("run", rows[i][3], converter0_run)
      `CHK("floor", rows[i][2], converter0_floor_sel)
      `CHK("discharge", rows[i][1], converter0_discharge)
      `CHK("fixed", rows[i][0], converter0_fixed_mode)
    end
    $display("test rows done");
    // Two bytes in one frame: the second lands in control B while running.
    qbc_host_i.wr(qbc_pkg::OFS_CONV0_CTRL_A, 2, 8'h80, 8'h3d);
    settle();
    `CHK("run_inc", 1'b1, converter0_run)
    `CHK("ilim_inc", 3'h7, converter0_current_limit_code)
    for (int c = 0; c < 8; c++)
    begin
      qbc_host_i.wr(qbc_pkg::OFS_CONV0_CTRL_B, 1, 8'(c * 9), 8'h00);
      settle();
      `CHK("ilim", (c < 2) ? 3'h2 : 3'(c), converter0_current_limit_code)
      `CHK("ramp", 3'(c), converter0_ramp_rate_code)
      qbc_host_i.rd(qbc_pkg::OFS_CONV0_CTRL_B, rd);
      `CHK("ctrl_b", 8'(c * 9), rd)
    end
    $display("test codes done");
    qbc_host_i.wr(qbc_pkg::OFS_STAT_CONV01, 1, 8'hff, 8'h00);
    qbc_host_i.rd(qbc_pkg::OFS_STAT_CONV01, rd);
    `CHK("status", 8'h4c, rd)
    qbc_host_i.wr(8'h40, 1, 8'hff, 8'h00);
    qbc_host_i.rd(8'h40, rd);
    `CHK("unmapped", 8'h00, rd)
    $display("test read_only done");
    // A masked limit event is recorded but kept off the interrupt line.
    qbc_host_i.wr(qbc_pkg::OFS_MASK_CONV01, 1, 8'h01, 8'h00);
    current_limit_hit = 4'h1;
    @(negedge clk_sys);
    current_limit_hit = 4'h0;
    settle();
    `CHK("irq_masked", 1'b1, irq_n)
    qbc_host_i.rd(qbc_pkg::OFS_INT_CONV01, rd);
    `CHK("flag", 8'h01, rd)
    qbc_host_i.wr(qbc_pkg::OFS_MASK_CONV01, 1, 8'h00, 8'h00);
    settle();
    `CHK("irq_open", 1'b0, irq_n)
    qbc_host_i.wr(qbc_pkg::OFS_INT_CONV01, 1, 8'h01, 8'h00);
    settle();
    `CHK("irq_clear", 1'b1, irq_n)
    $display("test interrupt done");
    // A short circuit has no mask bit, so its flag always drives the interrupt line.
    short_circuit = 4'h4;
    @(negedge clk_sys);
    short_circuit = 4'h0;
    settle();
    `CHK("irq_short", 1'b0, irq_n)
    qbc_host_i.rd(qbc_pkg::OFS_INT_CONV23, rd);
    `CHK("flag_short", 8'h02, rd)
    qbc_host_i.wr(qbc_pkg::OFS_INT_CONV23, 1, 8'h02, 8'h00);
    settle();
    `CHK("irq_short_clear", 1'b1, irq_n)
    // A masked ready event still records its flag and the measured current.
    qbc_host_i.wr(qbc_pkg::OFS_MASK_TOP, 1, 8'h01, 8'h00);
    load_current = 10'h2a5;
    load_ready = 1'b1;
    @(negedge clk_sys);
    load_ready = 1'b0;
    settle();
    `CHK("irq_ready_masked", 1'b1, irq_n)
    qbc_host_i.rd(qbc_pkg::OFS_INT_TOP, rd);
    `CHK("flag_ready", 8'h01, rd)
    qbc_host_i.rd(qbc_pkg::OFS_LOAD_HIGH, rd);
    `CHK("load_high", 8'h02, rd)
    qbc_host_i.rd(qbc_pkg::OFS_LOAD_LOW, rd);
    `CHK("load_low", 8'ha5, rd)
    $display("test events done");
    nv_load = 1'b1;
    @(negedge clk_sys);
    nv_load = 1'b0;
    qbc_host_i.rd(qbc_pkg::OFS_REVISION, rd);
    `CHK("revision", 8'h5a, rd)
    qbc_host_i.rd(qbc_pkg::OFS_CONV0_CTRL_B, rd);
    `CHK("nv_ctrl_b", 8'h09, rd)
    // A second reset in mid-run brings back the reset image.
    rst = 1'b1;
    @(negedge clk_sys);
    rst = 1'b0;
    settle();
    qbc_host_i.rd(qbc_pkg::OFS_CONV0_CTRL_A, rd);
    `CHK("ctrl_a_again", 8'hca, rd)
    $display("test reload done");
    finish_test();
  end
endmodule
